//--- hdl/sssi_device.sv
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module sssi_device (
  input logic sys_clk,
  input logic resetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [sssi_pkg::ADDR_W-1:0] paddr,
  input logic [sssi_pkg::DATA_W-1:0] pwdata,
  output logic [sssi_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic sleepMode,
  output logic wake,
  output logic irq,
  sssi_link_if.dev link
);
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_RX, I_TX, I_TXACK} sssi_i2c_st_t;
  typedef struct packed {
    logic [2:0] sckS;
    logic [2:0] mosiS;
    logic [2:0] ssS;
    logic [2:0] sclS;
    logic [2:0] sdaS;
    logic en;
    logic i2c;
    logic clock_idle_polarity;
    logic buffer_overwrite_enable;
    logic wakeEn;
    logic [sssi_pkg::ADDR7_W-1:0] addr;
    logic [7:0] txBuf;
    logic [7:0] rxBuf;
    logic [7:0] sh;
    logic txPend;
    logic rxFull;
    logic [3:0] cnt;
    sssi_i2c_st_t ist;
    logic rw;
    logic [sssi_pkg::EV_N-1:0] stat;
    logic [sssi_pkg::EV_N-1:0] ien;
    logic miso;
    logic sdaOe;
    logic wake;
    logic irq;
    logic [sssi_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } sssi_dev_state_t;
  // lines idle high, so syncs start high to avoid a false start or stop
  localparam sssi_dev_state_t DEV_RST = '{ssS: 3'h7, sclS: 3'h7, sdaS: 3'h7, ist: I_IDLE,
                                          default: '0};

  sssi_dev_state_t q;
  sssi_dev_state_t d;
  logic [sssi_pkg::EV_N-1:0] ev;
  logic [sssi_pkg::DATA_W-1:0] rdata;
  logic mapped;
  logic sckRise, sckFall, lead, trail, ssAct, ssFall, mosiBit;
  logic sclRise, sclFall, sdaBit, startC, stopC, done;

  assign sckRise = q.sckS[1] & ~q.sckS[2];
  assign sckFall = ~q.sckS[1] & q.sckS[2];
  assign lead = q.clock_idle_polarity ? sckFall : sckRise;
  assign trail = q.clock_idle_polarity ? sckRise : sckFall;
  assign ssAct = ~q.ssS[1];
  assign ssFall = ~q.ssS[1] & q.ssS[2];
  assign mosiBit = q.mosiS[1];
  assign sclRise = q.sclS[1] & ~q.sclS[2];
  assign sclFall = ~q.sclS[1] & q.sclS[2];
  assign sdaBit = q.sdaS[1];
  assign startC = q.sclS[1] & q.sclS[2] & ~q.sdaS[1] & q.sdaS[2];
  assign stopC = q.sclS[1] & q.sclS[2] & q.sdaS[1] & ~q.sdaS[2];
  assign done = psel & penable & q.pready;

  always_comb begin
    rdata = '0;
    mapped = 1'b1;
    case (paddr)
      sssi_pkg::REG_CTRL: begin
        rdata[sssi_pkg::CTL_EN] = q.en;
        rdata[sssi_pkg::CTL_I2C] = q.i2c;
        rdata[sssi_pkg::CTL_CKP] = q.clock_idle_polarity;
        rdata[sssi_pkg::CTL_BUFFER_OVERWRITE_ENABLE] = q.buffer_overwrite_enable;
        rdata[sssi_pkg::CTL_WAKE] = q.wakeEn;
        rdata[sssi_pkg::CTL_ADDR_LSB +: sssi_pkg::ADDR7_W] = q.addr;
      end
      sssi_pkg::REG_DATA: rdata[7:0] = q.rxBuf;
      sssi_pkg::REG_STAT: rdata[sssi_pkg::EV_N-1:0] = q.stat;
      sssi_pkg::REG_IEN: rdata[sssi_pkg::EV_N-1:0] = q.ien;
      sssi_pkg::REG_ICLR: rdata = '0;
      sssi_pkg::REG_PINS: rdata[0] = q.sckS[1];
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    ev = '0;
    d.sckS = {q.sckS[1:0], link.sck};
    d.mosiS = {q.mosiS[1:0], link.mosi};
    d.ssS = {q.ssS[1:0], link.ssN};
    d.sclS = {q.sclS[1:0], link.scl};
    d.sdaS = {q.sdaS[1:0], link.sda};
    // one wait state keeps prdata and pready straight from flops
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    if (psel && penable && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = ~mapped;
      d.prdata = rdata;
    end
    if (done && !pwrite && paddr == sssi_pkg::REG_DATA) begin
      d.rxFull = 1'b0;
    end
    if (!q.en) begin
      d.cnt = '0;
      d.ist = I_IDLE;
      d.sdaOe = 1'b0;
    end else if (!q.i2c) begin
      if (!ssAct) begin
        d.cnt = '0;
      end else if (ssFall) begin
        d.cnt = '0;
        d.miso = q.txPend ? q.txBuf[7] : q.sh[7];
        if (q.txPend) begin
          d.sh = q.txBuf;
          d.txPend = 1'b0;
        end
      end else if (lead) begin
        d.sh = {q.sh[6:0], mosiBit};
        d.cnt = q.cnt + 4'h1;
        if (q.cnt == sssi_pkg::BIT_LAST) begin
          d.cnt = '0;
          d.rxBuf = {q.sh[6:0], mosiBit};
          d.rxFull = 1'b1;
          ev[sssi_pkg::EV_BYTE] = 1'b1;
          ev[sssi_pkg::EV_OVF] = q.rxFull;
        end
      end else if (trail) begin
        // no new byte queued: the received byte goes out again
        if (q.cnt == '0 && q.txPend) begin
          d.sh = q.txBuf;
          d.miso = q.txBuf[7];
          d.txPend = 1'b0;
        end else begin
          d.miso = q.sh[7];
        end
      end
    end else begin
      if (startC) begin
        d.ist = I_ADDR;
        d.cnt = '0;
        d.sdaOe = 1'b0;
      end else if (stopC) begin
        d.ist = I_IDLE;
        d.sdaOe = 1'b0;
        ev[sssi_pkg::EV_STOP] = 1'b1;
      end else begin
        case (q.ist)
          I_ADDR, I_RX: begin
            if (sclRise) begin
              d.sh = {q.sh[6:0], sdaBit};
              d.cnt = q.cnt + 4'h1;
            end else if (sclFall && q.cnt == sssi_pkg::BYTE_BITS) begin
              d.ist = I_ACK;
              if (q.ist == I_ADDR) begin
                if (q.sh[7:1] == q.addr) begin
                  d.rw = q.sh[0];
                  d.rxBuf = q.sh;
                  d.rxFull = 1'b1;
                  d.sdaOe = 1'b1;
                  ev[sssi_pkg::EV_BYTE] = 1'b1;
                end else begin
                  d.ist = I_IDLE;
                end
              end else if (!q.rxFull) begin
                d.rxBuf = q.sh;
                d.rxFull = 1'b1;
                d.sdaOe = 1'b1;
                ev[sssi_pkg::EV_BYTE] = 1'b1;
              end else begin
                // unread byte: no ack, master sees a nack
                ev[sssi_pkg::EV_OVF] = 1'b1;
              end
            end
          end
          I_ACK: begin
            if (sclFall) begin
              d.cnt = '0;
              d.sdaOe = 1'b0;
              d.ist = q.rw ? I_TX : I_RX;
              if (q.rw) begin
                d.sh = q.txBuf;
                d.txPend = 1'b0;
                d.sdaOe = ~q.txBuf[7];
              end
            end
          end
          I_TX: begin
            if (sclRise) begin
              d.cnt = q.cnt + 4'h1;
            end else if (sclFall) begin
              if (q.cnt == sssi_pkg::BYTE_BITS) begin
                d.sdaOe = 1'b0;
                d.ist = I_TXACK;
              end else begin
                d.sh = {q.sh[6:0], 1'b0};
                d.sdaOe = ~q.sh[6];
              end
            end
          end
          I_TXACK: begin
            if (sclRise) begin
              if (sdaBit) begin
                d.ist = I_IDLE;
              end else begin
                ev[sssi_pkg::EV_BYTE] = 1'b1;
              end
            end else if (sclFall) begin
              d.ist = I_TX;
              d.cnt = '0;
              d.sh = q.txBuf;
              d.txPend = 1'b0;
              d.sdaOe = ~q.txBuf[7];
            end
          end
          default: d.ist = I_IDLE;
        endcase
      end
    end
    if (done && pwrite) begin
      case (paddr)
        sssi_pkg::REG_CTRL: begin
          d.en = pwdata[sssi_pkg::CTL_EN];
          d.i2c = pwdata[sssi_pkg::CTL_I2C];
          d.clock_idle_polarity = pwdata[sssi_pkg::CTL_CKP];
          d.buffer_overwrite_enable = pwdata[sssi_pkg::CTL_BUFFER_OVERWRITE_ENABLE];
          d.wakeEn = pwdata[sssi_pkg::CTL_WAKE];
          d.addr = pwdata[sssi_pkg::CTL_ADDR_LSB +: sssi_pkg::ADDR7_W];
        end
        sssi_pkg::REG_DATA: begin
          if (q.rxFull && !q.buffer_overwrite_enable) begin
            ev[sssi_pkg::EV_WCOL] = 1'b1;
          end else begin
            d.txBuf = pwdata[7:0];
            d.txPend = 1'b1;
          end
        end
        sssi_pkg::REG_IEN: d.ien = pwdata[sssi_pkg::EV_N-1:0];
        default: d.ien = d.ien;
      endcase
    end
    // set beats a clear in the same cycle
    if (done && pwrite && paddr == sssi_pkg::REG_ICLR) begin
      d.stat = q.stat & ~pwdata[sssi_pkg::EV_N-1:0];
    end
    d.stat = d.stat | ev;
    d.irq = |(d.stat & d.ien);
    d.wake = ev[sssi_pkg::EV_BYTE] & q.wakeEn & sleepMode;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign wake = q.wake;
  assign irq = q.irq;
  assign link.miso = q.miso;
  assign link.sdaDevOut = 1'b0;
  assign link.sdaDevOe = q.sdaOe;
endmodule

//--- hdl/sssi_host.sv
`timescale 1ns/1ps
module sssi_host (
  input logic sys_clk,
  input logic resetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [sssi_pkg::ADDR_W-1:0] paddr,
  input logic [sssi_pkg::DATA_W-1:0] pwdata,
  output logic [sssi_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  sssi_link_if.host link
);
  typedef struct packed {
    logic [1:0] misoS;
    logic [1:0] sdaS;
    logic clock_idle_polarity;
    logic [sssi_pkg::DIV_W-1:0] div;
    logic [sssi_pkg::DIV_W-1:0] divCnt;
    logic busy;
    sssi_pkg::sssi_op_t op;
    logic pre;
    logic [5:0] step;
    logic [8:0] sh;
    logic [7:0] rx;
    logic nack;
    logic sck;
    logic mosi;
    logic ssN;
    logic sclOe;
    logic sdaOe;
    logic stat;
    logic ien;
    logic irq;
    logic [sssi_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } sssi_host_state_t;
  localparam sssi_host_state_t HOST_RST = '{ssN: 1'b1, sdaS: 2'h3, misoS: 2'h0,
                                             div: sssi_pkg::DIV_DEFAULT,
                                             op: sssi_pkg::OP_SS_LOW, default: '0};

  sssi_host_state_t q;
  sssi_host_state_t d;
  logic [sssi_pkg::DATA_W-1:0] rdata;
  logic mapped, done, tick, fin;
  logic [3:0] bitNo;

  assign done = psel & penable & q.pready;
  assign tick = q.busy & (q.divCnt == q.div);
  assign bitNo = q.step[5:2];

  always_comb begin
    rdata = '0;
    mapped = 1'b1;
    case (paddr)
      sssi_pkg::REG_CTRL: begin
        rdata[sssi_pkg::CTL_CKP] = q.clock_idle_polarity;
        rdata[sssi_pkg::HCTL_DIV_LSB +: sssi_pkg::DIV_W] = q.div;
      end
      sssi_pkg::REG_DATA: rdata[7:0] = q.rx;
      sssi_pkg::REG_STAT: begin
        rdata[sssi_pkg::HST_BUSY] = q.busy;
        rdata[sssi_pkg::HST_NACK] = q.nack;
        rdata[sssi_pkg::HST_DONE] = q.stat;
        rdata[sssi_pkg::HST_RX_LSB +: 8] = q.rx;
      end
      sssi_pkg::REG_IEN: rdata[0] = q.ien;
      sssi_pkg::REG_ICLR: rdata = '0;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    d = q;
    fin = 1'b0;
    d.misoS = {q.misoS[0], link.miso};
    d.sdaS = {q.sdaS[0], link.sda};
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    if (psel && penable && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = ~mapped;
      d.prdata = rdata;
    end
    d.divCnt = (q.busy && !tick) ? q.divCnt + 8'h01 : '0;
    if (tick) begin
      d.step = q.step + 6'h01;
      case (q.op)
        sssi_pkg::OP_SPI: begin
          if (!q.step[0]) begin
            d.sck = ~q.clock_idle_polarity;
          end else begin
            // sample before going idle: miso trails sck by five clocks through both syncs
            d.rx = {q.rx[6:0], q.misoS[1]};
            d.sck = q.clock_idle_polarity;
            d.sh = {q.sh[7:0], 1'b0};
            d.mosi = q.sh[7];
            fin = (q.step == sssi_pkg::SPI_LAST);
          end
        end
        sssi_pkg::OP_STOP: begin
          case (q.step[1:0])
            2'h0: d.sdaOe = 1'b1;
            2'h1: d.sclOe = 1'b0;
            default: d.sdaOe = 1'b0;
          endcase
          fin = (q.step == sssi_pkg::STOP_LAST);
        end
        default: begin
          if (q.pre) begin
            case (q.step[1:0])
              2'h0: d.sdaOe = 1'b0;
              2'h1: d.sclOe = 1'b0;
              2'h2: d.sdaOe = 1'b1;
              default: d.sclOe = 1'b1;
            endcase
            if (q.step == sssi_pkg::PRE_LAST) begin
              d.pre = 1'b0;
              d.step = '0;
            end
          end else begin
            case (q.step[1:0])
              2'h0: d.sdaOe = ~q.sh[8];
              2'h1: d.sclOe = 1'b0;
              2'h2: begin
                d.sh = {q.sh[7:0], 1'b0};
                if (bitNo < sssi_pkg::BYTE_BITS) begin
                  d.rx = {q.rx[6:0], q.sdaS[1]};
                end else begin
                  d.nack = q.sdaS[1];
                end
              end
              default: begin
                d.sclOe = 1'b1;
                fin = (q.step == sssi_pkg::I2C_LAST);
              end
            endcase
          end
        end
      endcase
      if (fin) begin
        d.busy = 1'b0;
        d.step = '0;
      end
    end
    if (done && pwrite) begin
      case (paddr)
        sssi_pkg::REG_CTRL: begin
          d.clock_idle_polarity = pwdata[sssi_pkg::CTL_CKP];
          d.div = pwdata[sssi_pkg::HCTL_DIV_LSB +: sssi_pkg::DIV_W];
          if (!q.busy) begin
            d.sck = pwdata[sssi_pkg::CTL_CKP];
          end
        end
        sssi_pkg::REG_DATA: begin
          // commands while busy are dropped
          if (!q.busy) begin
            d.op = sssi_pkg::sssi_op_t'(pwdata[sssi_pkg::CMD_OP_LSB +: 3]);
            d.step = '0;
            d.busy = 1'b1;
            d.sh = {pwdata[7:0], 1'b1};
            d.pre = (d.op == sssi_pkg::OP_START);
            case (d.op)
              sssi_pkg::OP_SS_LOW: begin
                d.ssN = 1'b0;
                d.busy = 1'b0;
                fin = 1'b1;
              end
              sssi_pkg::OP_SS_HIGH: begin
                d.ssN = 1'b1;
                d.busy = 1'b0;
                fin = 1'b1;
              end
              sssi_pkg::OP_SPI: d.mosi = pwdata[7];
              sssi_pkg::OP_READ_ACK: d.sh = 9'h1FE;
              sssi_pkg::OP_READ_NACK: d.sh = 9'h1FF;
              default: d.pre = d.pre;
            endcase
          end
        end
        sssi_pkg::REG_IEN: d.ien = pwdata[0];
        default: d.ien = d.ien;
      endcase
    end
    if (done && pwrite && paddr == sssi_pkg::REG_ICLR && pwdata[0]) begin
      d.stat = 1'b0;
    end
    d.stat = d.stat | fin;
    d.irq = d.stat & d.ien;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
  assign link.sck = q.sck;
  assign link.mosi = q.mosi;
  assign link.ssN = q.ssN;
  assign link.sclHostOut = 1'b0;
  assign link.sclHostOe = q.sclOe;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOe = q.sdaOe;
endmodule

//--- hdl/sssi_link_if.sv
`timescale 1ns/1ps
interface sssi_link_if;
  logic sck;
  logic mosi;
  logic miso;
  logic ssN;
  logic sclHostOut;
  logic sclHostOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic scl;
  logic sda;
  // wired-and with pull-up: a released line floats high
  assign scl = ~(sclHostOe & ~sclHostOut);
  assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));
  modport dev (input sck, input mosi, input ssN, input scl, input sda,
               output miso, output sdaDevOut, output sdaDevOe);
  modport host (output sck, output mosi, output ssN, output sclHostOut, output sclHostOe,
                output sdaHostOut, output sdaHostOe, input miso, input scl, input sda);
endinterface

//--- hdl/sssi_pkg.sv
package sssi_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_IEN = 8'h0C;
  localparam logic [7:0] REG_ICLR = 8'h10;
  localparam logic [7:0] REG_PINS = 8'h14;
  // device control bits
  localparam int CTL_EN = 0;
  localparam int CTL_I2C = 1;
  localparam int CTL_CKP = 2;
  localparam int CTL_BUFFER_OVERWRITE_ENABLE = 3;
  localparam int CTL_WAKE = 4;
  localparam int CTL_ADDR_LSB = 8;
  localparam int ADDR7_W = 7;
  // device event bits
  localparam int EV_N = 4;
  localparam int EV_BYTE = 0;
  localparam int EV_OVF = 1;
  localparam int EV_WCOL = 2;
  localparam int EV_STOP = 3;
  // host control and status
  localparam int HCTL_DIV_LSB = 8;
  localparam int DIV_W = 8;
  localparam logic [7:0] DIV_DEFAULT = 8'h03;
  localparam int CMD_OP_LSB = 8;
  localparam int HST_BUSY = 0;
  localparam int HST_NACK = 1;
  localparam int HST_DONE = 2;
  localparam int HST_RX_LSB = 8;
  // bit and step counts
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [5:0] SPI_LAST = 6'h0F;
  localparam logic [5:0] I2C_LAST = 6'h23;
  localparam logic [5:0] PRE_LAST = 6'h03;
  localparam logic [5:0] STOP_LAST = 6'h02;
  typedef enum logic [2:0] {
    OP_SS_LOW, OP_SS_HIGH, OP_SPI, OP_START, OP_WRITE, OP_READ_ACK, OP_READ_NACK, OP_STOP
  } sssi_op_t;
endpackage

//--- testbench/sssi_link_sva.sv
`timescale 1ns/1ps
module sssi_link_sva (
  input logic sys_clk,
  input logic resetn,
  input logic sck,
  input logic mosi,
  input logic miso,
  input logic ssN,
  input logic sclHostOut,
  input logic sclHostOe,
  input logic sdaHostOut,
  input logic sdaHostOe,
  input logic sdaDevOut,
  input logic sdaDevOe,
  input logic scl,
  input logic sda
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // cycles since the last sck or ssN change; two sync flops plus a register sit before miso
  logic [3:0] quiet_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      quiet_q <= 4'hF;
    end else if ($changed(sck) || $changed(ssN)) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  a_dev_sda_od: assert property (sdaDevOe |-> sdaDevOut == 1'h0)
    else $error("device drives sda high");
  a_host_scl_od: assert property (sclHostOe |-> sclHostOut == 1'h0)
    else $error("host drives scl high");
  a_host_sda_od: assert property (sdaHostOe |-> sdaHostOut == 1'h0)
    else $error("host drives sda high");
  a_dev_sda_timing: assert property ($changed(sdaDevOe) |-> !$past(scl))
    else $error("device moved sda while scl high");
  a_miso_on_edge: assert property ($changed(miso) |-> quiet_q < 4'h8)
    else $error("miso moved without an external clock edge");
  a_mosi_hold: assert property ($changed(mosi) |=> $stable(mosi)[*3])
    else $error("mosi not held for a half period");
  a_sck_half_min: assert property ($changed(sck) |=> $stable(sck)[*3])
    else $error("sck half period too short");
  a_scl_half_min: assert property ($changed(scl) |=> $stable(scl)[*3])
    else $error("scl half period too short");
  cover property ($fell(sda) && scl);
  cover property ($rose(sda) && scl);
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int DEV = 0;
  localparam int HOST = 1;
  logic sys_clk = 1'h0;
  logic resetn = 1'h0;
  logic sleepMode = 1'h0;
  logic wake;
  logic psel [2];
  logic penable [2];
  logic pwrite [2];
  logic [7:0] paddr [2];
  logic [31:0] pwdata [2];
  logic [31:0] prdata [2];
  logic pready [2];
  logic pslverr [2];
  logic irq [2];
  logic [31:0] rd;
  logic err;
  int mismatches = 0;
  int samples_checked = 0;
  int wakeSeen = 0;

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (wake === 1'h1) begin
      wakeSeen++;
    end
  end

  sssi_link_if link_i ();
  sssi_device sssi_device_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel[DEV]),
    .penable(penable[DEV]), .pwrite(pwrite[DEV]), .paddr(paddr[DEV]), .pwdata(pwdata[DEV]),
    .prdata(prdata[DEV]), .pready(pready[DEV]), .pslverr(pslverr[DEV]),
    .sleepMode(sleepMode), .wake(wake), .irq(irq[DEV]), .link(link_i));
  sssi_host sssi_host_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel[HOST]),
    .penable(penable[HOST]), .pwrite(pwrite[HOST]), .paddr(paddr[HOST]),
    .pwdata(pwdata[HOST]), .prdata(prdata[HOST]), .pready(pready[HOST]),
    .pslverr(pslverr[HOST]), .irq(irq[HOST]), .link(link_i));
  sssi_link_sva sssi_link_sva_i (.sys_clk(sys_clk), .resetn(resetn), .sck(link_i.sck),
    .mosi(link_i.mosi), .miso(link_i.miso), .ssN(link_i.ssN),
    .sclHostOut(link_i.sclHostOut), .sclHostOe(link_i.sclHostOe),
    .sdaHostOut(link_i.sdaHostOut), .sdaHostOe(link_i.sdaHostOe),
    .sdaDevOut(link_i.sdaDevOut), .sdaDevOe(link_i.sdaDevOe), .scl(link_i.scl),
    .sda(link_i.sda));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; result left in rd and err
  task automatic apb(input int s, input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel[s] <= 1'h1;
    pwrite[s] <= w;
    paddr[s] <= a;
    pwdata[s] <= d;
    @(posedge sys_clk);
    penable[s] <= 1'h1;
    do begin
      @(posedge sys_clk);
    end while (pready[s] !== 1'h1);
    rd = prdata[s];
    err = pslverr[s];
    psel[s] <= 1'h0;
    penable[s] <= 1'h0;
  endtask

  // host command, then poll until idle; rd ends as host status
  task automatic hcmd(input logic [2:0] op, input logic [7:0] b);
    apb(HOST, 1'h1, sssi_pkg::REG_DATA, {21'h0, op, b});
    do begin
      apb(HOST, 1'h0, sssi_pkg::REG_STAT, 32'h0);
    end while (rd[sssi_pkg::HST_BUSY] !== 1'h0);
  endtask

  task automatic test_regs;
    apb(DEV, 1'h0, sssi_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h0, "device ctrl reset");
    apb(HOST, 1'h0, sssi_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'({sssi_pkg::DIV_DEFAULT, 8'h00}), "host ctrl reset");
    apb(DEV, 1'h0, 8'h18, 32'h0);
    chk(32'(err), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(HOST, 1'h0, 8'h18, 32'h0);
    chk(32'(err), 32'h1, "host unmapped error");
    apb(DEV, 1'h0, sssi_pkg::REG_PINS, 32'h0);
    chk(32'(rd[0]), 32'h0, "sck idle low");
    $display("test regs done");
  endtask

  task automatic test_spi;
    apb(DEV, 1'h1, sssi_pkg::REG_CTRL, 32'h1);
    apb(DEV, 1'h1, sssi_pkg::REG_IEN, 32'h1);
    apb(HOST, 1'h1, sssi_pkg::REG_IEN, 32'h1);
    apb(DEV, 1'h1, sssi_pkg::REG_DATA, 32'hA5);
    hcmd(sssi_pkg::OP_SS_LOW, 8'h00);
    hcmd(sssi_pkg::OP_SPI, 8'h3C);
    chk(32'(rd[15:8]), 32'hA5, "host rx");
    chk(32'(irq[HOST]), 32'h1, "host irq");
    apb(DEV, 1'h0, sssi_pkg::REG_STAT, 32'h0);
    chk(rd, 32'h1, "byte flag");
    chk(32'(irq[DEV]), 32'h1, "device irq");
    apb(DEV, 1'h0, sssi_pkg::REG_DATA, 32'h0);
    chk(rd, 32'h3C, "device rx");
    // masking must drop irq while the sticky bit stays
    apb(DEV, 1'h1, sssi_pkg::REG_IEN, 32'h0);
    apb(DEV, 1'h0, sssi_pkg::REG_STAT, 32'h0);
    chk(rd, 32'h1, "sticky flag");
    chk(32'(irq[DEV]), 32'h0, "masked irq");
    apb(DEV, 1'h1, sssi_pkg::REG_ICLR, 32'hF);
    apb(DEV, 1'h0, sssi_pkg::REG_STAT, 32'h0);
    chk(rd, 32'h0, "cleared flags");
    apb(HOST, 1'h1, sssi_pkg::REG_ICLR, 32'h1);
    hcmd(sssi_pkg::OP_SS_HIGH, 8'h00);
    chk(32'(wakeSeen), 32'h0, "no wake");
    $display("test spi done");
  endtask

  task automatic test_chain;
    apb(DEV, 1'h1, sssi_pkg::REG_CTRL, 32'h4);
    apb(HOST, 1'h1, sssi_pkg::REG_CTRL, 32'h0304);
    apb(DEV, 1'h0, sssi_pkg::REG_PINS, 32'h0);
    chk(32'(rd[0]), 32'h1, "sck idle high");
    apb(DEV, 1'h1, sssi_pkg::REG_CTRL, 32'h1D);
    sleepMode <= 1'h1;
    hcmd(sssi_pkg::OP_SS_LOW, 8'h00);
    hcmd(sssi_pkg::OP_SPI, 8'h81);
    hcmd(sssi_pkg::OP_SPI, 8'h00);
    chk(32'(rd[15:8]), 32'h81, "chain copy");
    chk(32'(wakeSeen != 0), 32'h1, "wake seen");
    hcmd(sssi_pkg::OP_SS_HIGH, 8'h00);
    // buffer still unread: overwrite enable must let the write in
    apb(DEV, 1'h1, sssi_pkg::REG_DATA, 32'h5A);
    apb(DEV, 1'h0, sssi_pkg::REG_STAT, 32'h0);
    chk(32'(rd[sssi_pkg::EV_WCOL]), 32'h0, "no collision");
    hcmd(sssi_pkg::OP_SS_LOW, 8'h00);
    hcmd(sssi_pkg::OP_SPI, 8'h00);
    chk(32'(rd[15:8]), 32'h5A, "overwrite sent");
    hcmd(sssi_pkg::OP_SS_HIGH, 8'h00);
    apb(DEV, 1'h1, sssi_pkg::REG_CTRL, 32'h15);
    apb(DEV, 1'h1, sssi_pkg::REG_DATA, 32'h77);
    apb(DEV, 1'h0, sssi_pkg::REG_STAT, 32'h0);
    chk(32'(rd[sssi_pkg::EV_WCOL]), 32'h1, "collision");
    sleepMode <= 1'h0;
    apb(DEV, 1'h0, sssi_pkg::REG_DATA, 32'h0);
    $display("test chain done");
  endtask

  task automatic test_i2c;
    apb(DEV, 1'h1, sssi_pkg::REG_CTRL, 32'h2A03);
    apb(DEV, 1'h1, sssi_pkg::REG_ICLR, 32'hF);
    hcmd(sssi_pkg::OP_START, 8'h54);
    chk(32'(rd[sssi_pkg::HST_NACK]), 32'h0, "address ack");
    apb(DEV, 1'h0, sssi_pkg::REG_DATA, 32'h0);
    chk(rd, 32'h54, "address byte");
    hcmd(sssi_pkg::OP_WRITE, 8'hC3);
    chk(32'(rd[sssi_pkg::HST_NACK]), 32'h0, "data ack");
    // rx still full: the next byte must go unacknowledged
    hcmd(sssi_pkg::OP_WRITE, 8'h3C);
    chk(32'(rd[sssi_pkg::HST_NACK]), 32'h1, "overrun nack");
    apb(DEV, 1'h0, sssi_pkg::REG_DATA, 32'h0);
    chk(rd, 32'hC3, "written byte");
    hcmd(sssi_pkg::OP_STOP, 8'h00);
    apb(DEV, 1'h0, sssi_pkg::REG_STAT, 32'h0);
    chk(32'(rd[sssi_pkg::EV_STOP]), 32'h1, "stop seen");
    chk(32'(rd[sssi_pkg::EV_OVF]), 32'h1, "overrun flag");
    apb(DEV, 1'h1, sssi_pkg::REG_DATA, 32'h96);
    hcmd(sssi_pkg::OP_START, 8'h55);
    chk(32'(rd[sssi_pkg::HST_NACK]), 32'h0, "read address ack");
    hcmd(sssi_pkg::OP_READ_ACK, 8'h00);
    chk(32'(rd[15:8]), 32'h96, "slave sent");
    hcmd(sssi_pkg::OP_READ_NACK, 8'h00);
    chk(32'(rd[15:8]), 32'h96, "slave repeat");
    hcmd(sssi_pkg::OP_STOP, 8'h00);
    hcmd(sssi_pkg::OP_START, 8'h56);
    chk(32'(rd[sssi_pkg::HST_NACK]), 32'h1, "foreign address");
    hcmd(sssi_pkg::OP_STOP, 8'h00);
    apb(DEV, 1'h0, sssi_pkg::REG_DATA, 32'h0);
    chk(rd, 32'h55, "rx untouched");
    $display("test i2c done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 2; i++) begin
      psel[i] = 1'h0;
      penable[i] = 1'h0;
      pwrite[i] = 1'h0;
      paddr[i] = 8'h00;
      pwdata[i] = 32'h0;
    end
    repeat (16) @(posedge sys_clk);
    resetn <= 1'h1;
    test_regs;
    test_spi;
    test_chain;
    test_i2c;
    stop_test;
  end

  // whole run is a few thousand clocks; this is far beyond it
  initial begin
    #1000000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end
endmodule
